/* logic/udhc_hw_config.sv */
// Device hardware configuration register and the pin behaviour it steers.
// Behaviour
// - Register is sixteen bits, kept across bus reset.
// - Command BA writes, BB reads one word.
// - Bit 14 selects external pull-up, no soft attach.
// - Bit 13 clear: slow clock out after delay.
// - Bit 12 set keeps clocks on in suspend.
// - Bits 11..8 divide clock output by N+1.
// - Divider change produces no glitch.
// - Bit 7 selects acknowledge-only DMA mode.
// - Bit 6 sets DMA request polarity.
// - Bit 5 sets DMA acknowledge polarity.
// - Bit 4 sets end-of-transfer polarity.
// - Bit 3: chip select low wakes, bus powered.
// - Bit 2: suspend output drives power switch.
// - Bit 1 selects level or pulsed interrupt.
// - Bit 0 sets interrupt output polarity.
// - Soft attach ignored when external pull-up set.
// - Suspend request one then zero enters suspend.
`timescale 1ns/1ps
`default_nettype none
`include "udhc_map.svh"

module udhc_hw_config #(
   parameter int SUSP_DELAY_CYC = `UDHC_SUSP_DELAY_CYC,
   parameter int SLOW_HALF_CYC  = `UDHC_SLOW_HALF_CYC
) (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Command port from the shared processor bus, same clock domain.
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        data_wr_valid,
   input  wire logic [15:0] data_wr,
   input  wire logic        data_rd_req,
   output logic [15:0]      data_rd,
   output logic             data_rd_valid,
   // Status from the rest of the controller.
   input  wire logic        usb_bus_reset,
   input  wire logic        suspend_request,
   input  wire logic        soft_attach_enable,
   input  wire logic        resume_done,
   input  wire logic        dc_irq_event,
   input  wire logic        dma_request_int,
   input  wire logic        end_of_transfer_int,
   // Pins from outside.
   input  wire logic        chip_select_n_pin,
   input  wire logic        vbus_pin,
   input  wire logic        device_dma_ack_pin,
   input  wire logic        end_of_transfer_pin,
   // Derived internal signals.
   output logic             dma_ack_int,
   output logic             end_of_transfer_in_int,
   output logic             dma_ack_only,
   output logic             soft_attach,
   output logic             suspended,
   output logic             remote_wakeup,
   output logic             osc_enable,
   // Pins to outside.
   output logic             clock_output_pin,
   output logic             device_dma_request,
   output logic             end_of_transfer_out,
   output logic             end_of_transfer_oe,
   output logic             device_irq_out,
   output logic             suspend_status_pin
);

   // ****************************************************************
   // Register and command decode
   // ****************************************************************
   udhc_pkg::udhc_cfg_t cfg;
   logic [1:0]          pending;  // [0] write armed, [1] read armed

   // Bus reset is deliberately not an input here: contents survive it.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cfg <= udhc_pkg::udhc_cfg_t'(`UDHC_RESET_VALUE);
      end else if (pending[0] && data_wr_valid && !cmd_valid) begin
         // A new command in the same cycle wins, as on the read path.
         cfg <= udhc_pkg::udhc_cfg_t'(data_wr);
      end
   end

   // A command arms exactly one following word transfer.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pending <= 2'b00;
      end else if (cmd_valid) begin
         pending <= {cmd_code == `UDHC_CMD_READ, cmd_code == `UDHC_CMD_WRITE};
      end else if ((pending[0] && data_wr_valid) || (pending[1] && data_rd_req)) begin
         pending <= 2'b00;
      end
   end

   // Read data is registered; one word per read command.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         data_rd       <= 16'h0000;
         data_rd_valid <= 1'b0;
      end else begin
         data_rd_valid <= pending[1] && data_rd_req && !cmd_valid;
         if (pending[1] && data_rd_req && !cmd_valid) begin
            data_rd <= cfg;
         end
      end
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [3:0] sync1;
   logic [3:0] sync2;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sync1 <= 4'hF;
         sync2 <= 4'hF;
      end else begin
         sync1 <= {chip_select_n_pin, vbus_pin, device_dma_ack_pin, end_of_transfer_pin};
         sync2 <= sync1;
      end
   end

   // ****************************************************************
   // Suspend sequencing
   // ****************************************************************
   udhc_pkg::udhc_susp_t state;
   logic                 req_prev;
   logic [31:0]          delay_cnt;
   logic                 wake;

   // Wake needs bus power; chip select alone would wake a detached device.
   assign wake = cfg.wake_on_chip_select && !sync2[3] && sync2[2];

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         req_prev <= 1'b0;
      end else begin
         req_prev <= suspend_request;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state     <= udhc_pkg::UDHC_RUN;
         delay_cnt <= '0;
      end else begin
         unique case (state)
            udhc_pkg::UDHC_RUN: begin
               delay_cnt <= '0;
               if (req_prev && !suspend_request) begin
                  state <= udhc_pkg::UDHC_WAIT;
               end
            end
            udhc_pkg::UDHC_WAIT: begin
               if (wake || resume_done || usb_bus_reset) begin
                  state <= udhc_pkg::UDHC_RUN;
               end else if (delay_cnt >= SUSP_DELAY_CYC - 1) begin
                  state <= udhc_pkg::UDHC_SLEEP;
               end else begin
                  delay_cnt <= delay_cnt + 1;
               end
            end
            udhc_pkg::UDHC_SLEEP: begin
               if (wake || resume_done || usb_bus_reset) begin
                  state <= udhc_pkg::UDHC_RUN;
               end
            end
            default: state <= udhc_pkg::UDHC_RUN;
         endcase
      end
   end

   assign suspended     = state != udhc_pkg::UDHC_RUN;
   assign remote_wakeup = suspended && wake;
   // Software must clear the always-on bit to reach suspend current.
   assign osc_enable    = cfg.clocks_always_on || state != udhc_pkg::UDHC_SLEEP;

   // ****************************************************************
   // Clock output
   // ****************************************************************
   logic       fast_clk;
   logic [7:0] slow_cnt;
   logic       slow_clk;

   udhc_clkdiv #(
      .W (4)
   ) u_div (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .enable  (state != udhc_pkg::UDHC_SLEEP),
      .divider (cfg.clock_out_divider),
      .clk_out (fast_clk)
   );

   // Slow suspend clock from a coarse counter.
   always_ff @(posedge ref_clk) begin
      if (!nrst || state != udhc_pkg::UDHC_SLEEP) begin
         slow_cnt <= 8'h00;
         slow_clk <= 1'b0;
      end else if (slow_cnt >= 8'(SLOW_HALF_CYC - 1)) begin
         slow_cnt <= 8'h00;
         slow_clk <= !slow_clk;
      end else begin
         slow_cnt <= slow_cnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         clock_output_pin <= 1'b0;
      end else if (state == udhc_pkg::UDHC_SLEEP) begin
         clock_output_pin <= !cfg.slow_clock_out_disable && slow_clk;
      end else begin
         clock_output_pin <= fast_clk;
      end
   end

   // ****************************************************************
   // Attach, DMA and power pins
   // ****************************************************************
   assign soft_attach  = soft_attach_enable && !cfg.external_pullup_sel;
   assign dma_ack_only = cfg.dma_ack_only_mode;
   assign dma_ack_int  = sync2[1] == cfg.dma_ack_polarity;
   assign end_of_transfer_in_int = sync2[0] == cfg.end_of_transfer_polarity;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         device_dma_request  <= 1'b0;
         end_of_transfer_out <= 1'b1;
         end_of_transfer_oe  <= 1'b0;
         suspend_status_pin  <= 1'b0;
      end else begin
         device_dma_request  <= dma_request_int ~^ cfg.dma_request_polarity;
         end_of_transfer_out <= end_of_transfer_int ~^ cfg.end_of_transfer_polarity;
         // Output driven only in acknowledge-only mode, else it is an input.
         end_of_transfer_oe  <= cfg.dma_ack_only_mode;
         suspend_status_pin  <= suspended && cfg.suspend_power_off_en;
      end
   end

   // ****************************************************************
   // Interrupt output
   // ****************************************************************
   logic       irq_prev;
   logic [3:0] pulse_cnt;
   logic       irq_active;

   // Pulse mode stretches each rising event to a fixed width.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         irq_prev  <= 1'b0;
         pulse_cnt <= 4'h0;
      end else begin
         irq_prev <= dc_irq_event;
         if (dc_irq_event && !irq_prev) begin
            pulse_cnt <= 4'(`UDHC_IRQ_PULSE_CYC);
         end else if (pulse_cnt != 4'h0) begin
            pulse_cnt <= pulse_cnt - 4'h1;
         end
      end
   end

   assign irq_active = cfg.irq_pulse_mode ? (pulse_cnt != 4'h0) : dc_irq_event;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         device_irq_out <= 1'b1;
      end else begin
         device_irq_out <= irq_active ~^ cfg.irq_polarity;
      end
   end

endmodule : udhc_hw_config
`default_nettype wire

/* logic/udhc_map.svh */
// Register map constants for the device hardware configuration register.
`ifndef UDHC_MAP_SVH
`define UDHC_MAP_SVH

// ****************************************************************
// Command codes and register layout
// ****************************************************************
`define UDHC_CMD_WRITE        8'hBA
`define UDHC_CMD_READ         8'hBB
`define UDHC_RESET_VALUE      16'h2340
`define UDHC_BIT_EXTPULL      14
`define UDHC_BIT_SLOW_DIS     13
`define UDHC_BIT_CLK_ON       12
`define UDHC_DIV_HI           11
`define UDHC_DIV_LO           8
`define UDHC_BIT_ACK_ONLY     7
`define UDHC_BIT_DRQ_POL      6
`define UDHC_BIT_DACK_POL     5
`define UDHC_BIT_EOT_POL      4
`define UDHC_BIT_WAKE_CS      3
`define UDHC_BIT_PWR_OFF      2
`define UDHC_BIT_IRQ_PULSE    1
`define UDHC_BIT_IRQ_POL      0

// ****************************************************************
// Timing
// ****************************************************************
`define UDHC_CLK_HZ           25000000
`define UDHC_SUSP_DELAY_US    2000
`define UDHC_SUSP_DELAY_CYC   ((`UDHC_SUSP_DELAY_US * (`UDHC_CLK_HZ / 1000000)))
`define UDHC_SLOW_CLK_HZ      100000
`define UDHC_SLOW_HALF_CYC    (`UDHC_CLK_HZ / (2 * `UDHC_SLOW_CLK_HZ))
`define UDHC_IRQ_PULSE_NS     166
`define UDHC_IRQ_PULSE_CYC    ((`UDHC_IRQ_PULSE_NS * (`UDHC_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* logic/udhc_pkg.sv */
// Types shared by the hardware configuration block.
package udhc_pkg;

   // ****************************************************************
   // Configuration register fields, bit 15 down to bit 0
   // ****************************************************************
   typedef struct packed {
      logic       reserved;
      logic       external_pullup_sel;
      logic       slow_clock_out_disable;
      logic       clocks_always_on;
      logic [3:0] clock_out_divider;
      logic       dma_ack_only_mode;
      logic       dma_request_polarity;
      logic       dma_ack_polarity;
      logic       end_of_transfer_polarity;
      logic       wake_on_chip_select;
      logic       suspend_power_off_en;
      logic       irq_pulse_mode;
      logic       irq_polarity;
   } udhc_cfg_t;

   // Suspend sequencing states.
   typedef enum logic [2:0] {
      UDHC_RUN   = 3'b001,
      UDHC_WAIT  = 3'b010,
      UDHC_SLEEP = 3'b100
   } udhc_susp_t;

endpackage : udhc_pkg

/* logic/udhc_clkdiv.sv */
// Glitch-free programmable divider for the clock output pin.
`timescale 1ns/1ps
`default_nettype none

module udhc_clkdiv #(
   parameter int W = 4
) (
   // Clock and reset.
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // Control.
   input  wire logic         enable,
   input  wire logic [W-1:0] divider,
   // Output.
   output logic              clk_out
);

   logic [W:0] count;
   logic [W:0] period;

   // Divider applies only at a period boundary so no runt pulse appears.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         count  <= '0;
         period <= '0;
      end else if (!enable) begin
         count  <= '0;
      end else if (count >= period) begin
         count  <= '0;
         period <= {1'b0, divider};
      end else begin
         count  <= count + 1'b1;
      end
   end

   // High for the first half of each period, registered.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         clk_out <= 1'b0;
      end else begin
         clk_out <= enable && ((count << 1) <= period);
      end
   end

endmodule : udhc_clkdiv
`default_nettype wire

/* bench/udhc_hw_config_properties.sv */
// Checker for the hardware configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "udhc_map.svh"
module udhc_hw_config_properties (
   // Clock and reset.
   input wire logic        ref_clk,
   input wire logic        nrst,
   // Command port.
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_code,
   input wire logic        data_wr_valid,
   input wire logic [15:0] data_wr,
   input wire logic        data_rd_req,
   input wire logic [15:0] data_rd,
   input wire logic        data_rd_valid,
   // Causes.
   input wire logic        soft_attach_enable,
   input wire logic        dc_irq_event,
   input wire logic        dma_request_int,
   input wire logic        device_dma_ack_pin,
   // Effects.
   input wire logic        dma_ack_int,
   input wire logic        dma_ack_only,
   input wire logic        soft_attach,
   input wire logic        suspended,
   input wire logic        remote_wakeup,
   input wire logic        osc_enable,
   input wire logic        device_dma_request,
   input wire logic        end_of_transfer_oe,
   input wire logic        device_irq_out,
   input wire logic        suspend_status_pin
);
   logic [15:0] shadow;
   logic        wr_arm;

   // Shadow of the register, rebuilt from bus traffic so no internal probe is needed.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         shadow <= `UDHC_RESET_VALUE;
         wr_arm <= 1'b0;
      end else if (cmd_valid) begin
         wr_arm <= (cmd_code == `UDHC_CMD_WRITE);
      end else if (data_wr_valid && wr_arm) begin
         wr_arm <= 1'b0;
         shadow <= data_wr;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_deep_sleep; suspended && !osc_enable && shadow[2]; endsequence

   // Outputs tied to the shadowed fields; the pin synchronisers account for the two-cycle lag.
   property p_read; data_rd_valid |-> data_rd == $past(shadow) && $past(data_rd_req); endproperty
   a_read: assert property (p_read) else $error("read word differs from register");
   property p_drq; 1'b1 |=> device_dma_request == ($past(dma_request_int) ~^ $past(shadow[6])); endproperty
   a_drq: assert property (p_drq) else $error("dma request level wrong");
   property p_ack; $past(nrst, 2) |-> dma_ack_int == ($past(device_dma_ack_pin, 2) ~^ shadow[5]); endproperty
   a_ack: assert property (p_ack) else $error("dma acknowledge decode wrong");
   property p_only; dma_ack_only == shadow[7]; endproperty
   a_only: assert property (p_only) else $error("dma mode wrong");
   property p_eoe; 1'b1 |=> end_of_transfer_oe == $past(shadow[7]); endproperty
   a_eoe: assert property (p_eoe) else $error("end of transfer enable wrong");
   property p_attach; soft_attach == (soft_attach_enable && !shadow[14]); endproperty
   a_attach: assert property (p_attach) else $error("soft attach with external pull-up");
   property p_irq; !shadow[1] |=> device_irq_out == ($past(dc_irq_event) ~^ $past(shadow[0])); endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");
   property p_sleep; s_deep_sleep |=> suspend_status_pin; endproperty
   a_sleep: assert property (p_sleep) else $error("power switch not driven");
   property p_osc; !suspended |-> osc_enable; endproperty
   a_osc: assert property (p_osc) else $error("oscillator off while awake");
   property p_wake; remote_wakeup |-> shadow[3]; endproperty
   a_wake: assert property (p_wake) else $error("wake without chip select enable");
endmodule : udhc_hw_config_properties

bind udhc_hw_config udhc_hw_config_properties u_props (.*);
`default_nettype wire

/* bench/udhc_host_model.sv */
// Host processor model driving the command port.
`timescale 1ns/1ps
`default_nettype none
`include "udhc_map.svh"
module udhc_host_model (
   // Clock.
   input  wire logic        ref_clk,
   // Command port.
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   output logic             data_wr_valid,
   output logic [15:0]      data_wr,
   output logic             data_rd_req,
   input  wire logic [15:0] data_rd,
   input  wire logic        data_rd_valid
);
   // Idle bus at time zero.
   initial begin
      {cmd_valid, data_wr_valid, data_rd_req} = 3'h0;
      cmd_code = 8'h00;
      data_wr  = 16'h0000;
   end

   // One command then exactly one word; gap lets the host pause between them.
   task automatic access(input logic wr, input logic [15:0] wv, input int gap,
                         output logic [15:0] rv, output logic ok);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_code  = wr ? `UDHC_CMD_WRITE : `UDHC_CMD_READ;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_code  = ~cmd_code;
      repeat (gap) @(negedge ref_clk);
      data_wr_valid = wr;
      data_rd_req   = !wr;
      data_wr       = wv;
      @(negedge ref_clk);
      {data_wr_valid, data_rd_req} = 2'h0;
      data_wr = ~wv;
      rv      = data_rd;
      ok      = wr | data_rd_valid;
   endtask : access
endmodule : udhc_host_model
`default_nettype wire

/* bench/tb_usb_device_hw_config.sv */
// Self-checking testbench for the hardware configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_hw_config;
   logic        ref_clk, nrst, cmd_valid, data_wr_valid, data_rd_req, data_rd_valid, ok;
   logic [7:0]  cmd_code;
   logic [15:0] data_wr, data_rd, cfg, rv;
   logic        usb_bus_reset, suspend_request, soft_attach_enable, resume_done, dc_irq_event;
   logic        dma_request_int, end_of_transfer_int, chip_select_n_pin, vbus_pin;
   logic        device_dma_ack_pin, end_of_transfer_pin, dma_ack_int, end_of_transfer_in_int;
   logic        dma_ack_only, soft_attach, suspended, remote_wakeup, osc_enable, clock_output_pin;
   logic        device_dma_request, end_of_transfer_out, end_of_transfer_oe, device_irq_out;
   logic        suspend_status_pin;
   logic [31:0] rnd;
   logic [3:0]  dv [3] = '{4'h1, 4'hF, 4'h6};
   int          fail_count = 0, compares = 0, seed = 32'h63D5, i, n, old;

   // Short suspend delay and slow clock keep the run brief.
   udhc_hw_config #(.SUSP_DELAY_CYC(20), .SLOW_HALF_CYC(4)) DUT (.*);
   udhc_host_model host (.*);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Level seen at a pin for a given activity and polarity bit.
   function automatic logic act(input logic lvl, pol);
      return lvl ~^ pol;
   endfunction : act

   task automatic chk_word(input logic [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   // Cycles between two rising edges of the clock output; bounded only after a first rising edge, so a pin that never rises waits for the timeout.
   task automatic period(output int p);
      int   k;
      logic prev;
      k    = 0;
      p    = 0;
      prev = clock_output_pin;
      while (k < 2 && p < 200) begin
         @(posedge ref_clk);
         #1;
         if (k == 1) p++;
         if (clock_output_pin && !prev) k++;
         prev = clock_output_pin;
      end
   endtask : period

   task automatic end_of_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      end_of_test;
   end

   initial begin
      {nrst, usb_bus_reset, suspend_request, soft_attach_enable} = 4'h1;
      {resume_done, dc_irq_event, dma_request_int, end_of_transfer_int} = 4'h0;
      {chip_select_n_pin, vbus_pin, device_dma_ack_pin, end_of_transfer_pin} = 4'hF;
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      host.access(1'b0, 16'h0000, 0, rv, ok);
      chk_word(rv, 16'h2340);
      // Random words, with all-zero and all-one corners, survive bus reset and steer the pins.
      for (i = 0; i < 12; i++) begin
         rnd = $random(seed);
         cfg = (i < 2) ? {16{i[0]}} : rnd[31:16];
         host.access(1'b1, cfg, i % 3, rv, ok);
         usb_bus_reset = i[0];
         {soft_attach_enable, end_of_transfer_int} = rnd[5:4];
         {dma_request_int, device_dma_ack_pin, end_of_transfer_pin, dc_irq_event} = rnd[3:0];
         host.access(1'b0, 16'h0000, i % 2, rv, ok);
         usb_bus_reset = 1'b0;
         repeat (3) @(negedge ref_clk);
         chk_bit(ok, 1'b1);
         chk_word(rv, cfg);
         chk_bit(device_dma_request, act(dma_request_int, cfg[6]));
         chk_bit(dma_ack_int, act(device_dma_ack_pin, cfg[5]));
         chk_bit(end_of_transfer_in_int, act(end_of_transfer_pin, cfg[4]));
         chk_bit(end_of_transfer_out, act(end_of_transfer_int, cfg[4]));
         chk_bit(end_of_transfer_oe, cfg[7]);
         chk_bit(dma_ack_only, cfg[7]);
         chk_bit(soft_attach, soft_attach_enable && !cfg[14]);
         if (!cfg[1]) chk_bit(device_irq_out, act(dc_irq_event, cfg[0]));
      end
      // A mid-run chip reset restores the reset value, unlike a bus reset.
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      host.access(1'b0, 16'h0000, 0, rv, ok);
      chk_word(rv, 16'h2340);
      // Pulsed, active-high interrupt: one event gives one pulse of fixed length.
      dc_irq_event = 1'b0;
      host.access(1'b1, 16'h0307, 0, rv, ok);
      repeat (8) @(negedge ref_clk);
      dc_irq_event = 1'b1;
      n = 0;
      repeat (12) begin
         @(negedge ref_clk);
         n += int'(device_irq_out);
      end
      chk_word(16'(n), 16'h0005);
      // Divider changes: the period in transition is old or new, never shorter.
      old = 4;
      for (i = 0; i < 3; i++) begin
         host.access(1'b1, {4'h0, dv[i], 8'h04}, 0, rv, ok);
         period(n);
         chk_bit(n == old || n == dv[i] + 1, 1'b1);
         period(n);
         chk_word(16'(n), 16'(dv[i] + 1));
         old = dv[i] + 1;
      end
      // Suspend with clocks stopped, then with clocks kept on; wake needs bus power.
      for (i = 0; i < 2; i++) begin
         cfg = i ? 16'h330C : 16'h030C;
         host.access(1'b1, cfg, 0, rv, ok);
         suspend_request = 1'b1;
         @(negedge ref_clk);
         suspend_request = 1'b0;
         repeat (30) @(negedge ref_clk);
         chk_bit(suspended, 1'b1);
         chk_bit(osc_enable, cfg[12]);
         chk_bit(suspend_status_pin, 1'b1);
         if (!cfg[13]) period(n);
         if (!cfg[13]) chk_word(16'(n), 16'h0008);
         {vbus_pin, chip_select_n_pin} = 2'h0;
         repeat (6) @(negedge ref_clk);
         chk_bit(suspended, 1'b1);
         vbus_pin = 1'b1;
         // The wake-up request shows for exactly the cycle before suspend is left.
         n = 0;
         repeat (6) begin
            @(negedge ref_clk);
            n += int'(remote_wakeup);
         end
         chk_word(16'(n), 16'h0001);
         chk_bit(suspended, 1'b0);
         chip_select_n_pin = 1'b1;
      end
      end_of_test;
   end
endmodule : tb_usb_device_hw_config
`default_nettype wire
